// ---- rtl/adcw_converter.sv ----
// Converter digital side: output word, bus drive, timing and shutdown
module adcw_converter (
   input  wire logic                            ref_clk,
   input  wire logic                            reset,
   input  wire logic                            conversion_start_n,
   input  wire logic                            chip_select_n,
   input  wire logic                            read_n,
   input  wire logic                            power_down_n,
   input  wire logic                            polarity_select,
   input  wire logic                            readback_mode,
   input  wire logic [adcw_pkg::STATUS_W-1:0]   readback_status_bits,
   input  wire logic [2:0]                      channel_addr,
   input  wire logic                            pair_sel,
   input  wire logic [adcw_pkg::RESULT_W-1:0]   core_code,
   output logic      [adcw_pkg::WORD_W-1:0]     data_out,
   output logic      [adcw_pkg::WORD_W-1:0]     data_oe,
   output logic                                 busy_n,
   output logic                                 standby_light,
   output logic                                 standby_deep,
   output logic                                 fifo_full
);
   localparam int WW = adcw_pkg::WORD_W;
   localparam int CW = adcw_pkg::CNT_W;

   adcw_pkg::adcw_pins_s  raw, meta_q, sync_q, prev_q;
   adcw_pkg::adcw_state_e st_q, st_d;
   adcw_pkg::adcw_word_s  cap_d, fifo_out;
   logic          deep_q, deep_d;
   logic          armed_q, armed_d;
   logic          pol_q, pol_d;
   logic [2:0]    addr_q, addr_d;
   logic          pair_q, pair_d;
   logic [WW-1:0] out_q, out_d, oe_q, oe_d;
   logic [WW-1:0] res_q, res_d;
   logic          res_valid_q, res_valid_d, consume;
   logic          busy_q, busy_d;
   logic          push, push_rdy, pop, head_valid;
   logic          tm_load, tm_run, tm_done;
   logic [CW-1:0] tm_count;
   logic          start_req, pd_fall, rd_rise, bus_rd;

   // Control pins from outside pass two flip-flops before use; address, pair, status and code inputs are used directly
   always_comb begin
      raw.start_n  = conversion_start_n;
      raw.cs_n     = chip_select_n;
      raw.rd_n     = read_n;
      raw.pd_n     = power_down_n;
      raw.polarity = polarity_select;
      raw.readback = readback_mode;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_q <= adcw_pkg::PINS_RST;
         sync_q <= adcw_pkg::PINS_RST;
         prev_q <= adcw_pkg::PINS_RST;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Decoded events from synchronised pins
   always_comb begin
      start_req = !sync_q.start_n && !sync_q.cs_n && armed_q && push_rdy;
      pd_fall   = prev_q.pd_n && !sync_q.pd_n;
      rd_rise   = !prev_q.rd_n && sync_q.rd_n && !sync_q.cs_n;
      bus_rd    = !sync_q.rd_n && !sync_q.cs_n;
   end

   // Interval timer on the internal clock
   adcw_timer #(.W(CW)) u_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .load    (tm_load),
      .count   (tm_count),
      .running (tm_run),
      .done    (tm_done)
   );

   // Result queue between conversion and host reads
   adcw_fifo #(.WIDTH(WW), .DEPTH(adcw_pkg::FIFO_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (push),
      .in_ready  (push_rdy),
      .in_data   (cap_d),
      .out_valid (head_valid),
      .out_ready (pop),
      .out_data  (fifo_out)
   );

   // Conversion and shutdown sequencing
   always_comb begin
      st_d     = st_q;
      deep_d   = deep_q;
      armed_d  = armed_q;
      pol_d    = pol_q;
      addr_d   = addr_q;
      pair_d   = pair_q;
      busy_d   = busy_q;
      tm_load  = 1'b0;
      tm_count = '0;
      push     = 1'b0;
      if (sync_q.start_n) begin
         armed_d = 1'b1;
      end
      cap_d.pair   = pair_q;
      cap_d.addr   = addr_q;
      cap_d.result = adcw_pkg::fmt_code(core_code, pol_q);
      unique case (st_q)
         adcw_pkg::ST_IDLE: begin
            if (pd_fall) begin
               st_d   = adcw_pkg::ST_DOWN;
               deep_d = sync_q.cs_n;
            end else if (start_req && !sync_q.readback) begin
               st_d     = adcw_pkg::ST_CONV;
               armed_d  = 1'b0;
               busy_d   = 1'b0;
               pol_d    = sync_q.polarity;
               addr_d   = channel_addr;
               pair_d   = pair_sel;
               tm_load  = 1'b1;
               tm_count = CW'(adcw_pkg::CONV_CYC);
            end
         end
         adcw_pkg::ST_CONV: begin
            if (tm_done) begin
               st_d     = adcw_pkg::ST_ACQ;
               push     = 1'b1;
               busy_d   = 1'b1;
               tm_load  = 1'b1;
               tm_count = CW'(adcw_pkg::ACQ_CYC);
            end
         end
         adcw_pkg::ST_ACQ: begin
            if (tm_done) begin
               st_d = adcw_pkg::ST_IDLE;
            end
         end
         adcw_pkg::ST_DOWN: begin
            if (sync_q.pd_n) begin
               st_d = deep_q ? adcw_pkg::ST_IDLE : adcw_pkg::ST_WAKE;
               if (!deep_q) begin
                  tm_load  = 1'b1;
                  tm_count = CW'(adcw_pkg::NAP_WAKE_CYC);
               end
            end
         end
         adcw_pkg::ST_WAKE: begin
            if (tm_done) begin
               st_d = adcw_pkg::ST_IDLE;
            end
         end
         default: st_d = adcw_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q    <= adcw_pkg::ST_IDLE;
         deep_q  <= 1'b0;
         armed_q <= 1'b0;
         pol_q   <= 1'b0;
         addr_q  <= 3'h0;
         pair_q  <= 1'b0;
         busy_q  <= 1'b1;
      end else begin
         st_q    <= st_d;
         deep_q  <= deep_d;
         armed_q <= armed_d;
         pol_q   <= pol_d;
         addr_q  <= addr_d;
         pair_q  <= pair_d;
         busy_q  <= busy_d;
      end
   end

   // Result word held until a host read of it ends; readback overlays status
   always_comb begin
      consume     = rd_rise && !sync_q.readback;
      pop         = head_valid && (!res_valid_q || consume) && !sync_q.readback;
      res_d       = pop ? fifo_out : res_q;
      res_valid_d = pop || (res_valid_q && !consume);
      out_d       = res_d;
      oe_d        = '0;
      if (sync_q.readback) begin
         out_d[adcw_pkg::STAT_HI_LSB +: adcw_pkg::STAT_HI_W] =
            readback_status_bits[adcw_pkg::STATUS_W-1 -: adcw_pkg::STAT_HI_W];
         out_d[WW-1 -: adcw_pkg::TAG_W] =
            readback_status_bits[adcw_pkg::TAG_W-1:0];
         if (bus_rd) begin
            oe_d[WW-1 -: adcw_pkg::TAG_W] = '1;
            oe_d[adcw_pkg::STAT_HI_LSB +: adcw_pkg::STAT_HI_W] = '1;
         end
      end else if (bus_rd) begin
         oe_d = '1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_q       <= adcw_pkg::WORD_RST;
         oe_q        <= '0;
         res_q       <= adcw_pkg::WORD_RST;
         res_valid_q <= 1'b0;
      end else begin
         out_q       <= out_d;
         oe_q        <= oe_d;
         res_q       <= res_d;
         res_valid_q <= res_valid_d;
      end
   end

   assign data_out      = out_q;
   assign data_oe       = oe_q;
   assign busy_n        = busy_q;
   assign standby_light = st_q == adcw_pkg::ST_DOWN && !deep_q;
   assign standby_deep  = st_q == adcw_pkg::ST_DOWN && deep_q;
   assign fifo_full     = !push_rdy;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic [CW-1:0] busy_cnt_q;
   always_ff @(posedge ref_clk) begin
      if (reset || busy_q) begin
         busy_cnt_q <= '0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 1'b1;
      end
   end

   bus_drive_a: assert property (|data_oe |-> $past(bus_rd))
      else $error("data driven without read and select");
   low_pins_a: assert property (sync_q.readback |=> data_oe[8:0] == '0)
      else $error("lower pins driven during readback");
   status_pins_a: assert property (sync_q.readback && bus_rd && $stable(sync_q.readback)
      |=> data_oe[15:9] == '1)
      else $error("status pins not driven during readback");
   conv_len_a: assert property ($fell(busy_n) |-> !busy_n [*8] ##0 (busy_cnt_q < CW'(adcw_pkg::CONV_MAX_CYC)))
      else $error("conversion length wrong");
   conv_max_a: assert property (busy_cnt_q <= CW'(adcw_pkg::CONV_MAX_CYC))
      else $error("conversion exceeds limit");
   conv_end_a: assert property ($fell(busy_n) |-> ##279 !busy_n ##1 busy_n)
      else $error("busy not raised at conversion end");
   start_gate_a: assert property ($fell(busy_n)
      |-> !$past(sync_q.cs_n) && !$past(sync_q.start_n))
      else $error("start without select");
   no_restart_a: assert property (!busy_n && !$fell(busy_n) |-> $stable(addr_q))
      else $error("conversion restarted");
   down_type_a: assert property (pd_fall && st_q == adcw_pkg::ST_IDLE
      |=> standby_deep == $past(sync_q.cs_n))
      else $error("standby type not from select");
   shut_a: assert property (standby_light || standby_deep |-> busy_n)
      else $error("conversion during shutdown");
   nap_wake_a: assert property (st_q == adcw_pkg::ST_DOWN && !deep_q && sync_q.pd_n
      |=> st_q == adcw_pkg::ST_WAKE ##39 st_q == adcw_pkg::ST_WAKE
      ##1 st_q == adcw_pkg::ST_IDLE)
      else $error("nap wake time wrong");
   fmt_a: assert property (push |-> cap_d.result[11] == (core_code[11] ^ pol_q))
      else $error("result format wrong");
   acq_a: assert property ($rose(busy_n) && st_q == adcw_pkg::ST_ACQ
      |-> ##[1:31] st_q == adcw_pkg::ST_IDLE)
      else $error("acquisition too long");

   // Cycles spent waking from light standby
   logic [CW-1:0] wake_cnt_q;
   always_ff @(posedge ref_clk) begin
      if (reset || st_q != adcw_pkg::ST_WAKE) begin
         wake_cnt_q <= '0;
      end else begin
         wake_cnt_q <= wake_cnt_q + 1'b1;
      end
   end

   wake_len_a: assert property (st_q == adcw_pkg::ST_WAKE && tm_done
      |-> wake_cnt_q == CW'(adcw_pkg::NAP_WAKE_CYC - 1))
      else $error("wake interval length wrong");
   word_keep_a: assert property (res_valid_q && !consume |=> res_q == $past(res_q))
      else $error("unread result replaced");
   read_word_a: assert property (bus_rd && !sync_q.readback && res_valid_q
      |=> data_out == $past(res_q))
      else $error("read shows wrong word");

   conv_c:  cover property ($rose(busy_n));
   read_c:  cover property (pop && consume);
   sleep_c: cover property ($rose(standby_deep));
   nap_c:   cover property ($fell(standby_light));
   rb_c:    cover property (sync_q.readback && bus_rd);
endmodule

// ---- rtl/adcw_pkg.sv ----
// Shared constants, types and helpers for the converter output block
package adcw_pkg;
   localparam int RESULT_W    = 12;
   localparam int TAG_W       = 4;
   localparam int WORD_W      = 16;
   localparam int STATUS_W    = 7;
   localparam int FIFO_DEPTH  = 32;
   localparam int CNT_W       = 9;
   // Timing in ns and derived cycle counts at ref_clk
   localparam int CLK_NS      = 5;
   localparam int CONV_TYP_NS = 1400;
   localparam int CONV_MAX_NS = 2000;
   localparam int ACQ_NS      = 150;
   localparam int THRU_NS     = 2500;
   localparam int NAP_WAKE_NS = 200;
   localparam int CONV_CYC    = CONV_TYP_NS / CLK_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
   localparam int ACQ_CYC     = (ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int THRU_CYC    = THRU_NS / CLK_NS;
   localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_NS - 1) / CLK_NS;
   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   // Status word split over data and tag pins
   localparam int STAT_HI_W   = 3;
   localparam int STAT_HI_LSB = 9;

   typedef struct packed {
      logic                pair;
      logic [2:0]          addr;
      logic [RESULT_W-1:0] result;
   } adcw_word_s;

   typedef struct packed {
      logic start_n;
      logic cs_n;
      logic rd_n;
      logic pd_n;
      logic polarity;
      logic readback;
   } adcw_pins_s;

   // Idle levels of the synchronised pins after reset
   localparam adcw_pins_s PINS_RST = '{start_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, pd_n: 1'b1,
                                       polarity: 1'b0, readback: 1'b0};

   typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_ACQ, ST_DOWN, ST_WAKE} adcw_state_e;

   // Offset binary core code to reported format
   function automatic logic [RESULT_W-1:0] fmt_code(input logic [RESULT_W-1:0] code,
                                                    input logic bipolar);
      fmt_code = bipolar ? {~code[RESULT_W-1], code[RESULT_W-2:0]} : code;
   endfunction
endpackage

// ---- rtl/adcw_fifo.sv ----
// Result FIFO with valid/ready on both sides
module adcw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // Pointer and fill count update
   always_comb begin
      push     = in_valid && in_ready;
      pop      = out_valid && out_ready;
      in_ready = cnt_q != (AW+1)'(DEPTH);
      out_valid = cnt_q != '0;
      out_data = mem[rd_q];
      wr_d     = push ? wr_q + 1'b1 : wr_q;
      rd_d     = pop ? rd_q + 1'b1 : rd_q;
      cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule

// ---- rtl/adcw_timer.sv ----
// Down counter for conversion, acquisition and wake intervals
module adcw_timer #(
   parameter int W = 9
) (
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              running,
   output logic              done
);
   logic [W-1:0] cnt_q, cnt_d;
   logic         done_q, done_d;

   // Load, count down, pulse at the last cycle
   always_comb begin
      cnt_d  = cnt_q;
      if (load) begin
         cnt_d = count;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      // Flag rides with the final count so an interval of N lasts N cycles
      done_d = cnt_d == W'(1);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign running = cnt_q != '0;
   assign done    = done_q;
endmodule

// ---- tb/adcw_bus_model.sv ----
// Host side data bus: resolves the pins the converter drives or floats
module adcw_bus_model (
   input  wire logic        ref_clk,
   input  wire logic [15:0] drive,
   input  wire logic [15:0] enable,
   output logic      [15:0] bus
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] last_q;

   // Floating bits flip each cycle so a stale value never passes
   always_ff @(posedge ref_clk) begin
      last_q <= bus;
   end

   // Per-pin resolution of driven and released lines
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         bus[i] = enable[i] ? drive[i] : ~last_q[i];
      end
   end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the converter output and shutdown block
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk = 0;
   logic        reset = 1;
   logic        start_n = 1;
   logic        cs_n = 0;
   logic        rd_n = 1;
   logic        pd_n = 1;
   logic        pol = 0;
   logic        rb_mode = 0;
   logic [6:0]  status = 7'h00;
   logic [2:0]  addr = 3'h0;
   logic        pair = 0;
   logic [11:0] code = 12'h000;
   logic [15:0] data_out;
   logic [15:0] data_oe;
   logic [15:0] bus;
   logic        busy_n;
   logic        sb_light;
   logic        sb_deep;
   logic        fifo_full;
   logic [15:0] exp_q[$];
   int          n_errors = 0;
   int          num_checks = 0;
   int          cyc = 0;

   adcw_converter adcw_converter_inst (
      .ref_clk(ref_clk), .reset(reset), .conversion_start_n(start_n),
      .chip_select_n(cs_n), .read_n(rd_n), .power_down_n(pd_n),
      .polarity_select(pol), .readback_mode(rb_mode),
      .readback_status_bits(status), .channel_addr(addr), .pair_sel(pair),
      .core_code(code), .data_out(data_out), .data_oe(data_oe),
      .busy_n(busy_n), .standby_light(sb_light), .standby_deep(sb_deep),
      .fifo_full(fifo_full));

   adcw_bus_model adcw_bus_model_inst (
      .ref_clk(ref_clk), .drive(data_out), .enable(data_oe), .bus(bus));

   // 200 MHz clock
   always begin
      #2.5 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One conversion; extra start pulses while busy must not restart it
   task automatic conv(input logic [11:0] c, input logic [2:0] a, input logic p, q);
      int k;
      int lo;
      k = 0;
      lo = 0;
      code <= c;
      addr <= a;
      pair <= p;
      pol <= q;
      start_n <= 0;
      while (busy_n !== 1'b0 && k < 20) begin
         clk(1);
         k++;
      end
      while (busy_n === 1'b0 && lo < 600) begin
         clk(1);
         lo++;
         if (lo == 10 || lo == 30) start_n <= 1;
         if (lo == 20) start_n <= 0;
      end
      chk(16'(lo), 16'(adcw_pkg::CONV_CYC));
      exp_q.push_back({p, a, q ? {~c[11], c[10:0]} : c});
      clk(40);
   endtask

   // Host read cycle; bus kept quiet otherwise
   task automatic do_read(output logic [15:0] v, output logic [15:0] oe);
      int k;
      k = 0;
      rd_n <= 0;
      while (data_oe === 16'h0000 && k < 10) begin
         clk(1);
         k++;
      end
      clk(1);
      v = bus;
      oe = data_oe;
      rd_n <= 1;
      clk(5);
      chk(data_oe, 16'h0000);
   endtask

   task automatic refused();
      start_n <= 0;
      clk(12);
      chk({15'h0000, busy_n}, 16'h0001);
      start_n <= 1;
      clk(4);
   endtask

   task automatic drain();
      logic [15:0] v;
      logic [15:0] oe;
      while (exp_q.size() > 0) begin
         do_read(v, oe);
         chk(oe, 16'hffff);
         chk(v, exp_q.pop_front());
      end
   endtask

   task automatic t_formats();
      conv(12'h123, 3'h5, 1'b1, 1'b0);
      conv(12'h8f0, 3'h2, 1'b0, 1'b1);
      conv(12'h7ff, 3'h7, 1'b1, 1'b1);
      conv(12'hfff, 3'h1, 1'b0, 1'b0);
      drain();
      $display("test formats done");
   endtask

   task automatic t_select();
      cs_n <= 1;
      refused();
      cs_n <= 0;
      clk(4);
      $display("test select done");
   endtask

   task automatic t_readback();
      logic [15:0] v;
      logic [15:0] oe;
      rb_mode <= 1;
      status <= 7'h5a;
      clk(5);
      do_read(v, oe);
      chk(oe, 16'hfe00);
      chk({9'h000, v[15:9]}, {9'h000, 4'ha, 3'h5});
      rb_mode <= 0;
      clk(5);
      $display("test readback done");
   endtask

   // Standby type follows select at power-down fall, then stays
   task automatic t_down(input logic sel);
      cs_n <= sel;
      clk(4);
      pd_n <= 0;
      clk(6);
      chk({14'h0000, sb_light, sb_deep}, {14'h0000, ~sel, sel});
      cs_n <= ~sel;
      clk(6);
      chk({14'h0000, sb_light, sb_deep}, {14'h0000, ~sel, sel});
      refused();
      pd_n <= 1;
      cs_n <= 0;
      clk(50);
      chk({14'h0000, sb_light, sb_deep}, 16'h0000);
      conv(12'h456, 3'h3, 1'b1, 1'b0);
      drain();
      $display("test shutdown done");
   endtask

   task automatic t_fifo();
      int n;
      n = 0;
      while (fifo_full !== 1'b1 && n < 40) begin
         conv(12'h100 + 12'(n), 3'(n), 1'b0, 1'b0);
         n++;
      end
      chk({15'h0000, fifo_full}, 16'h0001);
      refused();
      drain();
      chk({15'h0000, fifo_full}, 16'h0000);
      $display("test fifo done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      clk(12);
      reset <= 0;
      clk(8);
      t_formats();
      t_select();
      t_readback();
      t_down(1'b0);
      t_down(1'b1);
      t_fifo();
      close_out();
   end
endmodule
